// >>> include/scpwm_pkg.sv
// constants shared by the state-configurable timer and its input selector
package scpwm_pkg;
  localparam int unsigned NREG   = 8;
  localparam int unsigned NEV    = 8;
  localparam int unsigned NIN    = 5;
  localparam int unsigned NOUT   = 6;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEL_W  = 3;
  // register byte addresses
  localparam logic [7:0] A_CONFIG = 8'h00;
  localparam logic [7:0] A_CTRL   = 8'h04;
  localparam logic [7:0] A_LIMIT  = 8'h08;
  localparam logic [7:0] A_COUNT  = 8'h0C;
  localparam logic [7:0] A_STATE  = 8'h10;
  localparam logic [7:0] A_INSEL  = 8'h14;
  localparam logic [7:0] A_OUTPUT = 8'h18;
  localparam logic [7:0] A_ADCSEL = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_MASK   = 8'h24;
  localparam logic [7:0] A_MODE   = 8'h28;
  localparam logic [7:0] A_CAPSRC = 8'h30;
  localparam logic [2:0] A_MATCH_PG = 3'h2;  // 0x40..0x5C, one word per register
  localparam logic [2:0] A_EVC_PG   = 3'h3;  // 0x60..0x7C, one word per event
  // configuration fields
  localparam int unsigned CF_UNIFY   = 0;
  localparam int unsigned CF_CLKSEL  = 1;
  localparam int unsigned CF_CLKIN   = 2;
  localparam int unsigned CF_BIDIR_L = 5;
  localparam int unsigned CF_BIDIR_H = 6;
  // control fields
  localparam int unsigned CT_STOP_L = 0;
  localparam int unsigned CT_HALT_L = 1;
  localparam int unsigned CT_STOP_H = 2;
  localparam int unsigned CT_HALT_H = 3;
  // event control fields
  localparam int unsigned EV_MREG   = 0;
  localparam int unsigned EV_HIGH   = 3;
  localparam int unsigned EV_STMASK = 4;
  localparam int unsigned EV_NEXT   = 12;
  localparam int unsigned EV_LOADST = 15;
  localparam int unsigned EV_TOG    = 16;
  localparam int unsigned EV_LIMIT  = 22;
  localparam int unsigned EV_STOP   = 23;
  localparam int unsigned EV_HALT   = 24;
  localparam int unsigned EV_REV    = 25;
  localparam int unsigned EV_IOMODE = 26;
  localparam int unsigned EV_IOSEL  = 27;
  // reset values
  localparam logic [3:0]  CTRL_RST  = 4'hA;
  localparam logic [31:0] LIMIT_RST = 32'hFFFF_FFFF;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} scpwm_dir_t;
endpackage : scpwm_pkg

// >>> include/scpwm_sel_if.sv
// link between the timer core and its input selector
interface scpwm_sel_if;
  logic [11:0] sel;
  logic [4:0]  lvl;
  logic [4:0]  tog;
  modport timer (output sel, input lvl, input tog);
  modport mux   (input sel, output lvl, output tog);
endinterface : scpwm_sel_if

// >>> rtl/scpwm_insel.sv
// timer input selector: four muxed inputs plus one clock-source input
module scpwm_insel
  import scpwm_pkg::*;
(
  input  wire logic  pclk,                // system clock
  input  wire logic  presetn,             // async reset, active low
  input  wire logic  [3:0] pin_in,        // external pin signals
  input  wire logic  adc_thcmp,           // adc threshold-compare interrupt
  input  wire logic  comp_out,            // comparator output
  input  wire logic  core_transmit_event, // processor transmit event
  input  wire logic  core_a,              // core_a status
  input  wire logic  clk_src,             // clock source for fifth input
  scpwm_sel_if.mux   sif                  // selection and sampled inputs
);
  typedef struct packed {
    logic [4:0] lvl;
    logic [4:0] prev;
  } scpwm_insel_st_t;

  scpwm_insel_st_t r;
  scpwm_insel_st_t n;
  logic [7:0]      src;

  // four pins then four internal sources, selected by a 3-bit code each
  always_comb
  begin
    src = {core_a, core_transmit_event, comp_out, adc_thcmp, pin_in};
    n = r;
    for (int k = 0; k < 4; k++)
    begin
      n.lvl[k] = src[sif.sel[SEL_W*k +: SEL_W]];
    end
    n.lvl[4] = clk_src; // not selectable
    n.prev = r.lvl;
  end

  // one sample per pclk edge; a source faster than pclk would alias
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  assign sif.lvl = r.lvl;
  assign sif.tog = r.lvl ^ r.prev;
endmodule : scpwm_insel

// >>> rtl/scpwm_timer.sv
// state-configurable timer with match/capture events and pwm outputs
//
// Our own choices: the address map and the APB register port.
module scpwm_timer
  import scpwm_pkg::*;
(
  input  wire logic  pclk,                // apb clock, 25 MHz
  input  wire logic  presetn,             // async reset, active low
  input  wire logic  psel,                // apb select
  input  wire logic  penable,             // apb access phase
  input  wire logic  pwrite,              // apb write
  input  wire logic  [ADDR_W-1:0] paddr,  // apb byte address
  input  wire logic  [31:0] pwdata,       // apb write data
  output logic       [31:0] prdata,       // apb read data
  output logic       pready,              // apb ready
  output logic       pslverr,             // apb error on unmapped address
  input  wire logic  [3:0] pin_in,        // external pin inputs
  input  wire logic  adc_thcmp,           // adc threshold-compare interrupt
  input  wire logic  comp_out,            // comparator output
  input  wire logic  core_transmit_event, // processor transmit event
  input  wire logic  core_a,              // core_a status
  input  wire logic  clk_src,             // clock source on fifth input
  output logic       [NOUT-1:0] pwm_out,  // timer outputs to pins
  output logic       adc_trig,            // selected output to the adc
  output logic       irq                  // level interrupt
);
  typedef struct packed {
    logic [6:0]       cfg;
    logic [3:0]       ctrl;
    logic [31:0]      lim;
    logic [15:0]      cnt_h;
    logic [15:0]      cnt_l;
    scpwm_dir_t       dir_h;
    scpwm_dir_t       dir_l;
    logic [2:0]       state;
    logic [11:0]      insel;
    logic [5:0]       outp;
    logic [5:0]       outp_prev;
    logic [2:0]       adcsel;
    logic [7:0]       status;
    logic [7:0]       mask;
    logic [7:0]       mode;
    logic [31:0]      capsrc;
    logic [7:0][31:0] mreg;
    logic [7:0][31:0] evc;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
    logic             adc_trig;
  } scpwm_regs_t;

  localparam scpwm_regs_t RST_VAL = '{ctrl: CTRL_RST, lim: LIMIT_RST, dir_h: DIR_UP, dir_l: DIR_UP, default: '0};

  scpwm_regs_t r;
  scpwm_regs_t n;
  scpwm_sel_if sif ();

  logic [7:0]  fire;
  logic [5:0]  tog_acc;
  logic [10:0] io_tog;
  logic [3:0]  ctrl_set;
  logic        lim_l;
  logic        lim_h;
  logic        rev_l;
  logic        rev_h;
  logic        tick;
  logic        unify;
  logic        hi;
  logic        hit;
  logic        blocked;
  logic [2:0]  mi;
  logic [3:0]  iosel;
  logic [31:0] cnt32;
  logic [31:0] cmp_c;
  logic [31:0] cmp_m;
  logic [32:0] st_u;
  logic [32:0] st_l;
  logic [32:0] st_h;
  logic        acc;
  logic        known;
  logic        wr;
  logic [31:0] rd;
  logic [7:0]  wclr;

  // one counting step: returns {direction, value}
  function automatic logic [32:0] cnt_step(input logic [31:0] c, input logic [31:0] lim,
                                           input logic bidir, input logic dn, input logic force_lim);
    logic [31:0] v;
    logic        d;
    v = c;
    d = dn;
    if (!dn)
    begin
      if (c == lim || force_lim)
      begin
        if (bidir && c != 32'h0000_0000)
        begin
          d = DIR_DOWN; // turn at the limit
          v = c - 32'h0000_0001;
        end
        else
          v = 32'h0000_0000; // wrap restarts the shared period
      end
      else
        v = c + 32'h0000_0001;
    end
    else if (c == 32'h0000_0000)
    begin
      d = DIR_UP; // turn again at zero
      v = 32'h0000_0001;
    end
    else
      v = c - 32'h0000_0001;
    return {d, v};
  endfunction : cnt_step

  scpwm_insel u_insel (
    .pclk                (pclk),
    .presetn             (presetn),
    .pin_in              (pin_in),
    .adc_thcmp           (adc_thcmp),
    .comp_out            (comp_out),
    .core_transmit_event (core_transmit_event),
    .core_a              (core_a),
    .clk_src             (clk_src),
    .sif                 (sif.mux)
  );

  assign sif.sel = r.insel;

  // next-state logic: events, counters, then the apb slave
  always_comb
  begin
    n = r;
    unify = r.cfg[CF_UNIFY];
    cnt32 = {r.cnt_h, r.cnt_l};
    // count on every pclk, or on a rising edge of the chosen input
    tick = 1'b1;
    if (r.cfg[CF_CLKSEL])
      tick = (r.cfg[CF_CLKIN +: 3] < 3'd5) ? (sif.tog[r.cfg[CF_CLKIN +: 3]] & sif.lvl[r.cfg[CF_CLKIN +: 3]]) : 1'b0;
    io_tog = {r.outp ^ r.outp_prev, sif.tog};
    fire = '0;
    tog_acc = '0;
    ctrl_set = '0;
    lim_l = 1'b0;
    lim_h = 1'b0;
    rev_l = 1'b0;
    rev_h = 1'b0;
    hi = 1'b0;
    hit = 1'b0;
    blocked = 1'b0;
    mi = '0;
    iosel = '0;
    cmp_c = '0;
    cmp_m = '0;
    // event evaluation, only in states enabled in the event's mask
    for (int e = 0; e < NEV; e++)
    begin
      mi = r.evc[e][EV_MREG +: 3];
      hi = r.evc[e][EV_HIGH] && !unify;
      iosel = r.evc[e][EV_IOSEL +: 4];
      cmp_c = unify ? cnt32 : (hi ? {16'h0000, r.cnt_h} : {16'h0000, r.cnt_l});
      cmp_m = unify ? r.mreg[mi] : (hi ? {16'h0000, r.mreg[mi][31:16]} : {16'h0000, r.mreg[mi][15:0]});
      blocked = hi ? r.ctrl[CT_HALT_H] : r.ctrl[CT_HALT_L];
      if (r.evc[e][EV_IOMODE])
        hit = (iosel < 4'd11) ? io_tog[iosel] : 1'b0; // input or output toggle
      else
        hit = !r.mode[mi] && tick && (cmp_c == cmp_m); // a register in capture mode never matches
      fire[e] = hit && !blocked && r.evc[e][EV_STMASK + r.state];
      if (fire[e])
      begin
        tog_acc = tog_acc ^ r.evc[e][EV_TOG +: 6];
        if (hi)
        begin
          lim_h = lim_h | r.evc[e][EV_LIMIT];
          rev_h = rev_h ^ r.evc[e][EV_REV];
          ctrl_set[CT_STOP_H] = ctrl_set[CT_STOP_H] | r.evc[e][EV_STOP];
          ctrl_set[CT_HALT_H] = ctrl_set[CT_HALT_H] | r.evc[e][EV_HALT];
        end
        else
        begin
          lim_l = lim_l | r.evc[e][EV_LIMIT];
          rev_l = rev_l ^ r.evc[e][EV_REV];
          ctrl_set[CT_STOP_L] = ctrl_set[CT_STOP_L] | r.evc[e][EV_STOP];
          ctrl_set[CT_HALT_L] = ctrl_set[CT_HALT_L] | r.evc[e][EV_HALT];
        end
      end
    end
    // lowest-numbered firing event with a state load wins
    for (int e = NEV - 1; e >= 0; e--)
    begin
      if (fire[e] && r.evc[e][EV_LOADST])
        n.state = r.evc[e][EV_NEXT +: 3];
    end
    // capture registers load the whole counter on their chosen event
    for (int i = 0; i < NREG; i++)
    begin
      if (r.mode[i] && r.capsrc[4*i+3] && fire[r.capsrc[4*i +: 3]])
        n.mreg[i] = cnt32;
    end
    // counters: direction reversal applies before the step
    st_u = cnt_step(cnt32, r.lim, r.cfg[CF_BIDIR_L], r.dir_l ^ rev_l, lim_l);
    st_l = cnt_step({16'h0000, r.cnt_l}, {16'h0000, r.lim[15:0]}, r.cfg[CF_BIDIR_L], r.dir_l ^ rev_l, lim_l);
    st_h = cnt_step({16'h0000, r.cnt_h}, {16'h0000, r.lim[31:16]}, r.cfg[CF_BIDIR_H], r.dir_h ^ rev_h, lim_h);
    if (unify)
    begin
      if (tick && !r.ctrl[CT_STOP_L] && !r.ctrl[CT_HALT_L])
      begin
        {n.cnt_h, n.cnt_l} = st_u[31:0];
        n.dir_l = scpwm_dir_t'(st_u[32]);
      end
    end
    else
    begin
      if (tick && !r.ctrl[CT_STOP_L] && !r.ctrl[CT_HALT_L])
      begin
        n.cnt_l = st_l[15:0];
        n.dir_l = scpwm_dir_t'(st_l[32]);
      end
      if (tick && !r.ctrl[CT_STOP_H] && !r.ctrl[CT_HALT_H])
      begin
        n.cnt_h = st_h[15:0];
        n.dir_h = scpwm_dir_t'(st_h[32]);
      end
    end
    n.outp = r.outp ^ tog_acc;
    n.outp_prev = r.outp;
    // apb decode; one wait state, so pready rises in the second access cycle
    acc = psel && penable;
    known = (paddr[1:0] == 2'b00);
    rd = '0;
    case (paddr)
      A_CONFIG: rd = {25'h0, r.cfg};
      A_CTRL:   rd = {28'h0, r.ctrl};
      A_LIMIT:  rd = r.lim;
      A_COUNT:  rd = cnt32;
      A_STATE:  rd = {29'h0, r.state};
      A_INSEL:  rd = {20'h0, r.insel};
      A_OUTPUT: rd = {26'h0, r.outp};
      A_ADCSEL: rd = {29'h0, r.adcsel};
      A_STATUS: rd = {24'h0, r.status};
      A_MASK:   rd = {24'h0, r.mask};
      A_MODE:   rd = {24'h0, r.mode};
      A_CAPSRC: rd = r.capsrc;
      default:
      begin
        if (paddr[7:5] == A_MATCH_PG)
          rd = r.mreg[paddr[4:2]];
        else if (paddr[7:5] == A_EVC_PG)
          rd = r.evc[paddr[4:2]];
        else
          known = 1'b0;
      end
    endcase
    n.pready = acc && !r.pready;
    n.prdata = (acc && !r.pready && !pwrite && known) ? rd : '0;
    n.pslverr = acc && !r.pready && !known;
    wr = acc && r.pready && pwrite && known;
    wclr = (wr && paddr == A_STATUS) ? pwdata[7:0] : 8'h00;
    if (wr)
    begin
      case (paddr)
        A_CONFIG: n.cfg = pwdata[6:0];
        A_CTRL:   n.ctrl = pwdata[3:0];
        A_LIMIT:  n.lim = pwdata;
        A_COUNT:  {n.cnt_h, n.cnt_l} = pwdata;
        A_STATE:  n.state = pwdata[2:0];
        A_INSEL:  n.insel = pwdata[11:0];
        A_OUTPUT: n.outp = pwdata[5:0];
        A_ADCSEL: n.adcsel = pwdata[2:0];
        A_MASK:   n.mask = pwdata[7:0];
        A_MODE:   n.mode = pwdata[7:0];
        A_CAPSRC: n.capsrc = pwdata;
        default:
        begin
          if (paddr[7:5] == A_MATCH_PG)
            n.mreg[paddr[4:2]] = pwdata;
          else if (paddr[7:5] == A_EVC_PG)
            n.evc[paddr[4:2]] = pwdata;
        end
      endcase
    end
    // hardware sets win over a same-cycle software write or clear
    n.ctrl = n.ctrl | ctrl_set;
    n.status = (r.status & ~wclr) | fire;
    n.irq = |(n.status & n.mask);
    n.adc_trig = (n.adcsel < 3'd6) ? n.outp[n.adcsel] : 1'b0;
  end

  // all state in one register; reset leaves both halves halted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= RST_VAL;
    else
      r <= n;
  end

  assign prdata   = r.prdata;
  assign pready   = r.pready;
  assign pslverr  = r.pslverr;
  assign pwm_out  = r.outp;
  assign adc_trig = r.adc_trig;
  assign irq      = r.irq;
endmodule : scpwm_timer

// >>> bench/scpwm_properties.sv
// checker of bus timing and output relations at the timer's top ports
module scpwm_properties
  import scpwm_pkg::*;
(
  input wire logic              pclk,     // system clock
  input wire logic              presetn,  // async reset, active low
  input wire logic              psel,     // apb select
  input wire logic              penable,  // apb access phase
  input wire logic [ADDR_W-1:0] paddr,    // apb byte address
  input wire logic [31:0]       prdata,   // apb read data
  input wire logic              pready,   // apb ready
  input wire logic              pslverr,  // apb error
  input wire logic [NOUT-1:0]   pwm_out,  // timer outputs
  input wire logic              adc_trig, // adc trigger
  input wire logic              irq       // level interrupt
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one wait state exactly, then a single-cycle answer
  ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready not in 2nd access cycle");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held over one cycle");
  ready_access_a: assert property (pready |-> psel && penable && $past(penable)) else $error("pready outside access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero when idle");
  err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("pslverr misplaced");
  err_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned not refused");
  // the trigger copies one of the outputs, so it cannot stand alone
  trig_copy_a: assert property (adc_trig |-> pwm_out != '0) else $error("adc_trig without output");
  reset_quiet_a: assert property ($rose(presetn) |-> pwm_out == '0 && !irq && !adc_trig) else $error("outputs after reset");

  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property ($rose(adc_trig));
endmodule : scpwm_properties

bind scpwm_timer scpwm_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .adc_trig(adc_trig),
  .irq(irq));

// >>> bench/scpwm_src_model.sv
// model of the pins and on-chip sources feeding the timer inputs
module scpwm_src_model (
  input  wire logic pclk,                // system clock
  output logic [3:0] pin_in,             // external pins
  output logic      adc_thcmp,           // adc threshold event
  output logic      comp_out,            // comparator output
  output logic      core_transmit_event, // transmit event
  output logic      core_a,              // core_a
  output logic      clk_src              // fixed clock source
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] src_r = 9'h000; // index is the selector code, 8 is the clock source

  // sources are plain levels wired straight out
  assign {clk_src, core_a, core_transmit_event, comp_out, adc_thcmp, pin_in} = src_r;
  // two cycles high, three low: a fifth of pclk, inside the input rate limit
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      src_r[k] <= 1'b1;
      repeat (2) @(posedge pclk);
      src_r[k] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
endmodule : scpwm_src_model

// >>> bench/testbench.sv
// self-checking bench for the timer: apb tasks and event scenarios
module testbench
  import scpwm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_trig, irq, rerr;
  logic        adc_thcmp, comp_out, core_transmit_event, core_a, clk_src;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pin_in;
  logic [5:0]  pwm_out;
  int          fail_count, samples_checked;

  scpwm_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .adc_thcmp(adc_thcmp), .comp_out(comp_out), .core_transmit_event(core_transmit_event), .core_a(core_a),
    .clk_src(clk_src), .pwm_out(pwm_out), .adc_trig(adc_trig), .irq(irq));
  scpwm_src_model src (.pclk(pclk), .pin_in(pin_in), .adc_thcmp(adc_thcmp), .comp_out(comp_out),
    .core_transmit_event(core_transmit_event), .core_a(core_a), .clk_src(clk_src));

  task automatic final_report;
    $display("checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; the answer is taken at the rising edge that samples pready high
  // no cycle count is assumed here: only the watchdog ends a wait that never finishes
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // counts output 0 toggles over 60 cycles; trigger must follow output 0
  task automatic tog(input int lo, input int hi);
    int   t;
    logic p;
    t = 0;
    p = pwm_out[0];
    repeat (60)
    begin
      @(negedge pclk);
      t += int'(pwm_out[0] !== p);
      p = pwm_out[0];
      chk(32'(adc_trig), 32'(pwm_out[0]));
    end
    chk(32'(t >= lo && t <= hi), 32'h1);
  endtask : tog

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // watchdog sized well beyond the scenario length
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    final_report();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, 32'h0000_000A);
    rd(A_LIMIT, LIMIT_RST);
    rd(A_STATUS, 32'h0);
    acc(1'b0, 8'h2C, 32'h0);
    chk(32'(rerr), 32'h1);
    // a misaligned write is refused and leaves the register alone
    acc(1'b1, 8'h09, 32'h0000_0000);
    chk(32'(rerr), 32'h1);
    rd(A_LIMIT, LIMIT_RST);
    // split halves must not carry into the high half, unified must
    for (int u = 0; u < 2; u++)
    begin
      wr(A_CONFIG, 32'(u));
      wr(A_COUNT, 32'h0000_FFFF);
      wr(A_CTRL, 32'h0000_0008);
      wr(A_CTRL, 32'h0000_000A);
      acc(1'b0, A_COUNT, 32'h0);
      chk(rdat >> 16, 32'(u));
    end
    // every selector code, then the fixed clock source, clocks the low half
    wr(A_CTRL, 32'h0000_0008);
    for (int k = 0; k < 9; k++)
    begin
      wr(A_CONFIG, (k == 8) ? 32'h0000_0012 : 32'h0000_0002);
      wr(A_INSEL, 32'(k % 8));
      wr(A_COUNT, 32'h0);
      src.pulse(k, 3);
      repeat (4) @(posedge pclk);
      rd(A_COUNT, 32'h0000_0003);
    end
    // event 0: match 3 limits, toggles output 0, loads state 5, captures into reg 1
    wr(A_CTRL, 32'h0000_000A);
    // software drives the outputs directly; the new level shows at the edge that ends the transfer
    wr(A_OUTPUT, 32'h0000_002A);
    @(posedge pclk);
    chk(32'(pwm_out), 32'h0000_002A);
    wr(A_OUTPUT, 32'h0);
    wr(A_CONFIG, 32'h0000_0001);
    wr(A_COUNT, 32'h0);
    wr(8'h40, 32'h0000_0003);
    wr(8'h60, 32'h0041_DFF0);
    wr(A_MODE, 32'h0000_0002);
    wr(A_CAPSRC, 32'h0000_0080);
    wr(A_MASK, 32'h0000_0001);
    wr(A_CTRL, 32'h0);
    tog(14, 16);
    wr(A_CTRL, 32'h0000_000A);
    rd(A_STATE, 32'h0000_0005);
    rd(8'h44, 32'h0000_0003);
    chk(32'(irq), 32'h1);
    wr(A_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(A_MASK, 32'h0000_0001);
    wr(A_STATUS, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rd(A_STATUS, 32'h0);
    wr(A_ADCSEL, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk(32'(adc_trig), 32'h0);
    // up-down with limit 3 hits the match once per six cycles
    wr(A_ADCSEL, 32'h0);
    wr(A_CONFIG, 32'h0000_0021);
    wr(8'h60, 32'h0001_0FF0);
    wr(A_LIMIT, 32'h0000_0003);
    wr(A_COUNT, 32'h0);
    wr(A_CTRL, 32'h0);
    tog(9, 11);
    final_report();
  end
endmodule : testbench
